// ==== core/boot_table_loader.sv ====
// Purpose: Validate and decode the OEM boot descriptor table
// Assumes: Software loads both table copies through the register port
// Notes: Validation runs one table byte per clock after a start command
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - First word gives byte count covered by the CRC.
// - Word 0x08 is key block address, also top of application flash.
// - Word 0x0C points to serial memory config pointer list, zero ended.
// - First app address at 0x10, format at 0x14; formats 0, 1, 2.
// - Second app at 0x18, format at 0x1C; zero address means absent.
// - Word 0x20 counts extra digest objects; counts above fifteen rejected.
// - Word 0x24 holds verification key address; zero means no key.
// - Word 0x1FC holds CRC16-CCITT in upper half, lower half zero.
// - Flags bits 1:0 pick boot clock; 25, 8, 50 MHz, 3 reserved.
// - Chosen boot clock holds after boot until firmware overrides it.
// - Flags bits 4:2 pick debug wait window; 20,10,1,0,100 ms.
// - Flags bit 31, default one, enables app authentication in normal stage; auth_required resets to zero, not to AUTH_RESET.
// - In secure stage every table modification is refused.
// - Secure digest is truncated SHA-256 compared against fuses.
// - If primary table fails, validate redundant copy and use it.
module boot_table_loader
    import boot_table_pkg::*;
#(
    parameter int MS_CYCLES = boot_table_pkg::MS_CYCLES_DEFAULT
)(
    input wire logic clock,
    input wire logic rst,
    input wire logic [10:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data,
    input wire logic secure_stage_pin,
    input wire logic normal_stage,
    input wire logic digest_match,
    output logic table_valid,
    output logic table_invalid,
    output logic use_redundant,
    output logic boot_done,
    output logic debug_window,
    output logic [31:0] key_block_address,
    output logic [31:0] serial_mem_config_pointer,
    output logic serial_mem_present,
    output logic [31:0] first_app_address,
    output logic [1:0] first_app_format,
    output logic [31:0] second_app_address,
    output logic [1:0] second_app_format,
    output logic second_app_present,
    output logic [31:0] verify_key_address,
    output logic verify_key_present,
    output logic [3:0] digest_object_count,
    output logic [1:0] boot_clock_select,
    output logic auth_required,
    output logic app_in_range
);
    import boot_table_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    if (MS_CYCLES < 1)
    begin : bad_ms_cycles
        $error("MS_CYCLES must be at least one");
    end

    typedef enum {IDLE, CRC_RUN, CHECK, WAIT_WIN, DONE} state_t;

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {data, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [31:0] wait_ms(input logic [2:0] code);
        case (code)
            3'h1: return 32'd10;
            3'h2: return 32'd1;
            3'h3: return 32'd0;
            3'h4: return 32'd100;
            default: return 32'd20;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Two table copies; the array is not reset, software must load it
    logic [31:0] table_mem [0:255];
    state_t state;
    logic bank;
    logic [8:0] byte_index;
    logic [15:0] crc;
    logic [31:0] wait_count;
    logic secure_meta;
    logic secure_stage;
    logic write_refused;
    logic clock_override;
    logic [1:0] override_code;
    logic [1:0] table_clock;
    logic start_cmd;
    logic [31:0] size_word;
    logic [31:0] flags_word;
    logic [31:0] crc_word;
    logic [31:0] cur_word;
    logic [7:0] cur_byte;
    logic size_ok;
    logic crc_ok;
    logic table_ok;
    logic [31:0] next_wait;

    function automatic logic [7:0] word_index(input logic b, input logic [10:0] ofs);
        return {b, ofs[8:2]};
    endfunction

    assign size_word = table_mem[word_index(bank, TABLE_SIZE_OFS)];
    assign flags_word = table_mem[word_index(bank, BOOT_FLAGS_OFS)];
    assign crc_word = table_mem[word_index(bank, TABLE_CRC_OFS)];
    assign cur_word = table_mem[{bank, byte_index[8:2]}];
    assign cur_byte = 8'(cur_word >> {byte_index[1:0], 3'b000});
    assign size_ok = (size_word != 32'h0000_0000) && (size_word <= MAX_TABLE_BYTES);
    assign crc_ok = (crc_word[31:16] == crc) && (crc_word[15:0] == 16'h0000);
    assign table_ok = size_ok && crc_ok
        && (table_mem[word_index(bank, TABLE_MAGIC_OFS)] == TABLE_MAGIC)
        && (table_mem[word_index(bank, DIGEST_COUNT_OFS)] <= MAX_DIGEST_OBJECTS);
    assign start_cmd = write_strobe && (address == CONTROL_OFS)
        && write_data[CTRL_START_BIT] && (state == IDLE || state == DONE);
    assign next_wait = wait_ms(flags_word[WAIT_SEL_LSB +: 3]) * 32'(MS_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // Life-cycle pin comes from fuse logic outside this clock
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            secure_meta <= 1'b0;
            secure_stage <= 1'b0;
        end
        else
        begin
            secure_meta <= secure_stage_pin;
            secure_stage <= secure_meta;
        end
    end

    // Table writes; refused once secure
    always_ff @(posedge clock)
    begin
        if (write_strobe && (address < CONTROL_OFS) && !secure_stage)
        begin
            table_mem[address[9:2]] <= write_data;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            write_refused <= 1'b0;
        end
        else if (write_strobe && (address < CONTROL_OFS) && secure_stage)
        begin
            write_refused <= 1'b1;
        end
        else if (start_cmd)
        begin
            write_refused <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Validation sequence
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= IDLE;
            bank <= 1'b0;
            byte_index <= 9'h000;
            crc <= CRC_INIT;
            wait_count <= 32'h0000_0000;
        end
        else
        begin
            case (state)
                IDLE, DONE:
                begin
                    if (start_cmd)
                    begin
                        state <= CRC_RUN;
                        bank <= 1'b0;
                        byte_index <= 9'h000;
                        crc <= CRC_INIT;
                    end
                end
                CRC_RUN:
                begin
                    // Bad size skips straight to the verdict
                    if (!size_ok || (32'(byte_index) >= size_word))
                    begin
                        state <= CHECK;
                    end
                    else
                    begin
                        crc <= crc_byte(crc, cur_byte);
                        byte_index <= byte_index + 9'h001;
                    end
                end
                CHECK:
                begin
                    if (table_ok)
                    begin
                        state <= WAIT_WIN;
                        wait_count <= next_wait;
                    end
                    else if (!bank)
                    begin
                        state <= CRC_RUN;
                        bank <= 1'b1;
                        byte_index <= 9'h000;
                        crc <= CRC_INIT;
                    end
                    else
                    begin
                        state <= DONE;
                    end
                end
                WAIT_WIN:
                begin
                    if (wait_count == 32'h0000_0000)
                    begin
                        state <= DONE;
                    end
                    else
                    begin
                        wait_count <= wait_count - 32'h0000_0001;
                    end
                end
                default:
                begin
                    state <= IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Verdict flags
    always_ff @(posedge clock)
    begin
        if (rst || start_cmd)
        begin
            table_valid <= 1'b0;
            table_invalid <= 1'b0;
            use_redundant <= 1'b0;
        end
        else if (state == CHECK)
        begin
            table_valid <= table_ok;
            table_invalid <= !table_ok && bank;
            use_redundant <= table_ok && bank;
        end
    end

    // Decoded fields only load from a table that passed
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            key_block_address <= 32'h0000_0000;
            serial_mem_config_pointer <= 32'h0000_0000;
            first_app_address <= 32'h0000_0000;
            first_app_format <= 2'h0;
            second_app_address <= 32'h0000_0000;
            second_app_format <= 2'h0;
            verify_key_address <= 32'h0000_0000;
            digest_object_count <= 4'h0;
            table_clock <= CLOCK_SEL_RESET;
            auth_required <= 1'b0;
        end
        else if (state == CHECK && table_ok)
        begin
            key_block_address <= table_mem[word_index(bank, KEY_BLOCK_OFS)];
            serial_mem_config_pointer <= table_mem[word_index(bank, SERIAL_CFG_OFS)];
            first_app_address <= table_mem[word_index(bank, FIRST_APP_OFS)];
            first_app_format <= fmt(table_mem[word_index(bank, FIRST_FMT_OFS)]);
            second_app_address <= table_mem[word_index(bank, SECOND_APP_OFS)];
            second_app_format <= fmt(table_mem[word_index(bank, SECOND_FMT_OFS)]);
            verify_key_address <= table_mem[word_index(bank, VERIFY_KEY_OFS)];
            digest_object_count <= table_mem[word_index(bank, DIGEST_COUNT_OFS)][3:0];
            // Reserved code falls back to the default clock
            table_clock <= (flags_word[CLOCK_SEL_LSB +: 2] == CLOCK_SEL_RESERVED)
                ? CLOCK_SEL_RESET : flags_word[CLOCK_SEL_LSB +: 2];
            auth_required <= flags_word[AUTH_BIT] && normal_stage;
        end
    end

    // Unknown formats read as basic
    function automatic logic [1:0] fmt(input logic [31:0] w);
        return (w <= MAX_APP_FORMAT) ? w[1:0] : 2'h0;
    endfunction

    // Firmware override of boot clock; table choice holds until then
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            clock_override <= 1'b0;
            override_code <= CLOCK_SEL_RESET;
        end
        else if (write_strobe && (address == CONTROL_OFS))
        begin
            clock_override <= write_data[CTRL_CLK_OVR_BIT];
            override_code <= write_data[CTRL_CLK_CODE_LSB +: 2];
        end
    end

    assign boot_clock_select = clock_override ? override_code : table_clock;
    assign serial_mem_present = table_valid && (serial_mem_config_pointer != 32'h0000_0000);
    assign second_app_present = table_valid && (second_app_address != 32'h0000_0000);
    assign verify_key_present = table_valid && (verify_key_address != 32'h0000_0000);
    assign app_in_range = table_valid && (first_app_address < key_block_address);
    assign debug_window = (state == WAIT_WIN);
    // Secure stage also needs the fused digest to agree
    assign boot_done = (state == DONE) && table_valid && (!secure_stage || digest_match);

    ////////////////////////////////////////////////////////////////////////////
    // Register reads, one cycle latency; unmapped reads zero
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            read_data <= 32'h0000_0000;
        end
        else if (read_strobe)
        begin
            if (address < CONTROL_OFS)
            begin
                read_data <= table_mem[address[9:2]];
            end
            else if (address == CONTROL_OFS)
            begin
                read_data <= {28'h000_0000, override_code, clock_override, 1'b0};
            end
            else if (address == STATUS_OFS)
            begin
                read_data <= {24'h00_0000, secure_stage, write_refused, boot_done,
                    debug_window, use_redundant, table_invalid, table_valid,
                    state == CRC_RUN || state == CHECK};
            end
            else
            begin
                read_data <= 32'h0000_0000;
            end
        end
        else
        begin
            read_data <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    secure_write_block_a: assert property (
        write_strobe && address < CONTROL_OFS && secure_stage
        |=> table_mem[$past(address[9:2])] == $past(table_mem[address[9:2]]))
        else $error("Table changed in secure stage");
    invalid_no_decode_a: assert property (
        state == CHECK && !table_ok |=> $stable(key_block_address) && $stable(table_clock))
        else $error("Fields decoded from bad table");
    redundant_retry_a: assert property (
        state == CHECK && !table_ok && !bank |=> state == CRC_RUN && bank)
        else $error("Redundant copy not tried");
    digest_limit_a: assert property (
        state == CHECK && table_ok |-> table_mem[word_index(bank, DIGEST_COUNT_OFS)] <= 32'd15)
        else $error("Digest count above fifteen accepted");
    crc_layout_a: assert property (
        state == CHECK && table_ok |-> crc_word[15:0] == 16'h0000 && crc_word[31:16] == crc)
        else $error("CRC word accepted wrongly");
    wait_load_a: assert property (
        state == CHECK && table_ok && flags_word[4:2] == 3'h3 |=> ##1 state == DONE)
        else $error("Zero wait window not immediate");
    clock_reserved_a: assert property (
        table_valid |-> table_clock != CLOCK_SEL_RESERVED)
        else $error("Reserved clock code used");
    clock_hold_a: assert property (
        !clock_override && $stable(clock_override) && $stable(table_clock)
        |-> $stable(boot_clock_select))
        else $error("Boot clock changed without cause");
    auth_flag_a: assert property (
        state == CHECK && table_ok
        |=> auth_required == ($past(flags_word[31]) && $past(normal_stage)))
        else $error("Authentication enable wrong");
    second_absent_a: assert property (
        table_valid && second_app_address == 32'h0000_0000 |-> !second_app_present)
        else $error("Absent second app reported");
    app_limit_a: assert property (
        app_in_range |-> first_app_address < key_block_address)
        else $error("App beyond key block");
    crc_span_a: assert property (
        state == CRC_RUN && size_ok |-> 32'(byte_index) <= size_word)
        else $error("CRC ran past object size");
    fmt_range_a: assert property (
        first_app_format != 2'h3)
        else $error("Bad format decoded");
    key_zero_a: assert property (
        verify_key_address == 32'h0000_0000 |-> !verify_key_present)
        else $error("Zero key reported present");
    digest_gate_a: assert property (
        boot_done && secure_stage |-> digest_match)
        else $error("Secure boot without digest");
    list_ptr_a: assert property (
        serial_mem_present |-> serial_mem_config_pointer != 32'h0000_0000)
        else $error("Null config list reported");

    primary_pass_c: cover property (state == CHECK && table_ok && !bank);
    redundant_pass_c: cover property (state == CHECK && table_ok && bank);
    both_fail_c: cover property (state == CHECK && !table_ok && bank);
    refused_write_c: cover property (write_refused);
endmodule // boot_table_loader

`default_nettype wire

// ==== core/boot_table_pkg.sv ====
// Purpose: Constants for the boot descriptor table loader
// Assumes: 32-bit table words, byte offsets as printed
// Notes: Bank 1 holds the redundant copy of the table
package boot_table_pkg;
    // Table word offsets (bytes)
    localparam logic [10:0] TABLE_SIZE_OFS = 11'h000;
    localparam logic [10:0] TABLE_MAGIC_OFS = 11'h004;
    localparam logic [10:0] KEY_BLOCK_OFS = 11'h008;
    localparam logic [10:0] SERIAL_CFG_OFS = 11'h00C;
    localparam logic [10:0] FIRST_APP_OFS = 11'h010;
    localparam logic [10:0] FIRST_FMT_OFS = 11'h014;
    localparam logic [10:0] SECOND_APP_OFS = 11'h018;
    localparam logic [10:0] SECOND_FMT_OFS = 11'h01C;
    localparam logic [10:0] DIGEST_COUNT_OFS = 11'h020;
    localparam logic [10:0] VERIFY_KEY_OFS = 11'h024;
    localparam logic [10:0] BOOT_FLAGS_OFS = 11'h1F8;
    localparam logic [10:0] TABLE_CRC_OFS = 11'h1FC;
    localparam logic [10:0] REDUNDANT_BASE = 11'h200;
    localparam logic [10:0] CONTROL_OFS = 11'h400;
    localparam logic [10:0] STATUS_OFS = 11'h404;
    // Field layout
    localparam int CLOCK_SEL_LSB = 0;
    localparam int WAIT_SEL_LSB = 2;
    localparam int AUTH_BIT = 31;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLK_OVR_BIT = 1;
    localparam int CTRL_CLK_CODE_LSB = 2;
    // Values
    localparam logic [31:0] TABLE_MAGIC = 32'h0121_1220;
    localparam logic [31:0] MAX_DIGEST_OBJECTS = 32'h0000_000F;
    localparam logic [31:0] MAX_TABLE_BYTES = 32'h0000_01FC;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [1:0] CLOCK_SEL_RESET = 2'h0;
    localparam logic [1:0] CLOCK_SEL_RESERVED = 2'h3;
    localparam logic [2:0] WAIT_SEL_RESET = 3'h0;
    localparam logic AUTH_RESET = 1'b1;
    localparam logic [31:0] MAX_APP_FORMAT = 32'h0000_0002;
    // Timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int MS_IN_NS = 1000000;
    localparam int MS_CYCLES_DEFAULT = MS_IN_NS / CLOCK_PERIOD_NS;
    typedef enum logic [1:0] {
        CLK_FLL_25,
        CLK_IMO_8,
        CLK_FLL_50,
        CLK_RESERVED
    } clock_sel_t;
endpackage

// ==== verif/boot_table_loader_tb_top.sv ====
// Purpose: Self-checking bench for the boot descriptor table loader
// Assumes: MS_CYCLES shortened to 2 so wait windows stay short
// Notes: Random table fields from a fixed seed, plus refusal corners
`timescale 1ns/100ps
`default_nettype none
module boot_table_loader_tb_top;
import boot_table_pkg::*;
logic clock = 1'b0;
logic rst = 1'b1;
logic [10:0] address = 11'h000;
logic [31:0] write_data = 32'h0000_0000;
logic write_strobe = 1'b0;
logic read_strobe = 1'b0;
logic secure_stage_pin = 1'b0;
logic normal_stage = 1'b1;
logic digest_match = 1'b1;
logic [31:0] read_data, key_block_address, serial_mem_config_pointer;
logic [31:0] first_app_address, second_app_address, verify_key_address;
logic [1:0] first_app_format, second_app_format, boot_clock_select;
logic [3:0] digest_object_count;
logic table_valid, table_invalid, use_redundant, boot_done, debug_window;
logic serial_mem_present, second_app_present, verify_key_present, auth_required, app_in_range;
logic [31:0] t [10];
logic [31:0] key, ser, a1, f1, a2, f2, vk, flg, cnt, v;
int bad_count = 0;
int tests_run = 0;
int win = 0;
integer seed = 32'haf87_6e19;

always #50 clock = ~clock;

boot_table_loader #(.MS_CYCLES(2)) u_boot_table_loader (
    .clock(clock), .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .secure_stage_pin(secure_stage_pin), .normal_stage(normal_stage),
    .digest_match(digest_match), .table_valid(table_valid), .table_invalid(table_invalid),
    .use_redundant(use_redundant), .boot_done(boot_done), .debug_window(debug_window),
    .key_block_address(key_block_address),
    .serial_mem_config_pointer(serial_mem_config_pointer),
    .serial_mem_present(serial_mem_present), .first_app_address(first_app_address),
    .first_app_format(first_app_format), .second_app_address(second_app_address),
    .second_app_format(second_app_format), .second_app_present(second_app_present),
    .verify_key_address(verify_key_address), .verify_key_present(verify_key_present),
    .digest_object_count(digest_object_count), .boot_clock_select(boot_clock_select),
    .auth_required(auth_required), .app_in_range(app_in_range)
);

////////////////////////////////////////////////////////////////
task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
        bad_count++;
        $display("Error %s expected %h seen %h", name, exp, got);
    end
endtask

// A gap cycle after each strobe so no signal is assigned twice at one edge
task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
endtask

task automatic rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1;
    d = read_data;
endtask

task automatic wait_on(input bit done_flag);
    int n;
    n = 0;
    #1;
    while ((done_flag ? boot_done : (table_valid | table_invalid)) !== 1'b1 && n < 2000)
    begin
        win += int'(debug_window === 1'b1);
        @(posedge clock);
        #1;
        n++;
    end
    if (n == 2000)
    begin
        bad_count++;
        $display("Error wait expected %h seen %h", 1'b1, 1'b0);
        stop_test();
    end
endtask

// Window length in cycles for the bench's two cycles per ms, plus the zero count
function automatic int win_len(input logic [2:0] code);
    int ms;
    case (code)
        3'h1: ms = 10;
        3'h2: ms = 1;
        3'h3: ms = 0;
        3'h4: ms = 100;
        default: ms = 20;
    endcase
    return ms * 2 + 1;
endfunction

// Bytes taken little-endian, MSB first into the shift register
function automatic logic [15:0] crc16(input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++)
    begin
        c = c ^ {t[i / 4][8 * (i % 4) +: 8], 8'h00};
        for (int k = 0; k < 8; k++)
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
endfunction

task automatic load(input logic [10:0] b, input logic [31:0] c, input logic [31:0] bad);
    cnt = c;
    t = '{32'h0000_0028, TABLE_MAGIC, key, ser, a1, f1, a2, f2, cnt, vk};
    for (int i = 0; i < 10; i++)
        wr(b + 11'(4 * i), t[i]);
    wr(b + BOOT_FLAGS_OFS, flg);
    wr(b + TABLE_CRC_OFS, {crc16(40), 16'h0000} ^ bad);
endtask

////////////////////////////////////////////////////////////////
initial
begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("clock_select", 32'(CLOCK_SEL_RESET), 32'(boot_clock_select));
    check("valid_reset", 32'h0, 32'(table_valid));
    for (int i = 0; i < 4; i++)
    begin
        key = 32'h1008_0000;
        a1 = (i == 1) ? 32'h1009_0000 : 32'h1000_0400;
        ser = (i == 2) ? 32'h0000_0000 : $random(seed);
        a2 = (i == 0) ? 32'h0000_0000 : $random(seed);
        vk = (i == 1) ? 32'h0000_0000 : $random(seed);
        f1 = 32'(i);
        f2 = 32'(3 - i);
        flg = {1'($random(seed)), 26'h0, 3'($unsigned($random(seed)) % 5), 2'(i)};
        normal_stage <= 1'($random(seed));
        load(11'h000, (i == 3) ? 32'h0000_000F : 32'($unsigned($random(seed)) % 15), 0);
        wr(CONTROL_OFS, 32'h0000_0001);
        wait_on(0);
        check("valid", 32'h1, 32'(table_valid));
        check("key_block", key, key_block_address);
        check("in_range", 32'(a1 < key), 32'(app_in_range));
        check("serial_cfg", ser, serial_mem_config_pointer);
        check("serial_present", 32'(ser != 0), 32'(serial_mem_present));
        check("first_app", a1, first_app_address);
        check("first_fmt", (f1 > 2) ? 0 : f1, 32'(first_app_format));
        check("second_app", a2, second_app_address);
        check("second_fmt", (f2 > 2) ? 0 : f2, 32'(second_app_format));
        check("second_present", 32'(a2 != 0), 32'(second_app_present));
        check("digest_count", cnt, 32'(digest_object_count));
        check("verify_key", vk, verify_key_address);
        check("key_present", 32'(vk != 0), 32'(verify_key_present));
        check("auth", 32'(flg[31] & normal_stage), 32'(auth_required));
        check("clock_sel", (i == 3) ? 0 : i, 32'(boot_clock_select));
        win = 0;
        wait_on(1);
        check("window_len", 32'(win_len(flg[4:2])), 32'(win));
        check("window_off", 32'h0, 32'(debug_window));
        check("clock_hold", (i == 3) ? 0 : i, 32'(boot_clock_select));
    end
    wr(CONTROL_OFS, 32'h0000_0006);
    #1;
    check("clock_override", 32'h1, 32'(boot_clock_select));
    wr(CONTROL_OFS, 32'h0000_0000);
    // Primary count of sixteen is rejected, redundant copy takes over
    load(11'h000, 32'h0000_0010, 0);
    load(REDUNDANT_BASE, 32'h0000_0003, 0);
    wr(CONTROL_OFS, 32'h0000_0001);
    wait_on(0);
    check("redundant", 32'h1, 32'(use_redundant));
    check("redundant_count", 32'h3, 32'(digest_object_count));
    // Bad CRC upper half, then nonzero lower half
    load(11'h000, 32'h0000_0003, 32'h0001_0000);
    load(REDUNDANT_BASE, 32'h0000_0003, 32'h0000_0001);
    wr(CONTROL_OFS, 32'h0000_0001);
    wait_on(0);
    check("invalid", 32'h1, 32'(table_invalid));
    check("valid_fail", 32'h0, 32'(table_valid));
    check("present_fail", 32'h0, 32'(serial_mem_present));
    rd(KEY_BLOCK_OFS, v);
    check("table_word", key, v);
    rd(11'h408, v);
    check("unmapped", 32'h0, v);
    secure_stage_pin <= 1'b1;
    repeat (4) @(posedge clock);
    wr(KEY_BLOCK_OFS, 32'hdead_beef);
    rd(KEY_BLOCK_OFS, v);
    check("secure_word", key, v);
    rd(STATUS_OFS, v);
    check("refused_flag", 32'h0000_0040, v & 32'h0000_0040);
    stop_test();
end
endmodule // boot_table_loader_tb_top
`default_nettype wire
